/* hw/tdi_line_camera_control_video.sv */
// The APB interface to the registers and the register addresses were chosen for this implementation.
`default_nettype none
module tdi_line_camera_control_video #(
	parameter int LINE_PIXELS = 512,
	parameter bit WIDE_STAGE_SET = 1'b0
) (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Saved store erase to typical values
	input wire logic nv_erase_i,
	// Control pins
	input wire logic line_sync_in_i,
	input wire logic framing_sel_n_i,
	input wire logic stage_count_sel_lo_i,
	input wire logic stage_count_sel_hi_i,
	// Sensor pixel stream
	input wire logic sensor_valid_i,
	input wire camera_pkg::pixel_t sensor_data_i,
	output logic sensor_ready_o,
	// Video output
	output camera_pkg::pixel_t video_o,
	output logic pixel_clk_o,
	output logic line_valid_o,
	input wire logic rx_ready_i,
	// Status
	output logic [6:0] stage_count_o,
	output logic framing_o,
	output logic slave_mode_o
);

	initial begin
		if (LINE_PIXELS < 1 || LINE_PIXELS > 1023) begin
			$error("LINE_PIXELS out of range");
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pins_in;
	logic [3:0] s1_reg, s2_reg, s3_reg, pin_reg;
	logic [3:0] pin_next;
	assign pins_in = {stage_count_sel_hi_i, stage_count_sel_lo_i, framing_sel_n_i, line_sync_in_i};

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : pin_reg[i];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			s1_reg <= 4'he;
			s2_reg <= 4'he;
			s3_reg <= 4'he;
			pin_reg <= 4'he;
		end else if (ce_i) begin
			s1_reg <= pins_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			pin_reg <= pin_next;
		end
	end

	// ------------------------------------------------------------
	// Line timing and mode
	// ------------------------------------------------------------
	camera_pkg::mode_t mode_reg, mode_next;
	logic sync_d_reg, sync_d_next;
	logic [3:0] high_cnt_reg, high_cnt_next;
	logic sync_armed_reg, sync_armed_next;
	logic [9:0] line_cnt_reg, line_cnt_next;
	logic [9:0] words_left_reg, words_left_next;
	logic framing_reg, framing_next;
	logic [6:0] stage_reg, stage_next;
	logic line_start;
	logic pop;

	always_comb begin
		mode_next = mode_reg;
		sync_d_next = pin_reg[0];
		high_cnt_next = high_cnt_reg;
		sync_armed_next = sync_armed_reg;
		line_cnt_next = line_cnt_reg + 10'h001;
		line_start = 1'b0;
		// Qualify the sync high time before starting a line
		if (pin_reg[0] && !sync_d_reg) begin
			high_cnt_next = 4'h1;
			sync_armed_next = 1'b1;
		end else if (pin_reg[0] && sync_armed_reg) begin
			if (high_cnt_reg >= 4'(camera_pkg::SYNC_MIN_CYC - 1)) begin
				sync_armed_next = 1'b0;
				line_start = 1'b1;
				mode_next = camera_pkg::MODE_SLAVE;
				line_cnt_next = 10'h000;
			end else begin
				high_cnt_next = high_cnt_reg + 4'h1;
			end
		end else if (!pin_reg[0]) begin
			sync_armed_next = 1'b0;
		end
		framing_next = (mode_next == camera_pkg::MODE_MASTER) && !pin_reg[1];
		if (mode_reg == camera_pkg::MODE_MASTER && !line_start) begin
			if (framing_reg && line_cnt_reg >= 10'(camera_pkg::FRAMING_LINE_CYC - 1)) begin
				line_start = 1'b1;
				line_cnt_next = 10'h000;
			end else if (line_cnt_reg >= 10'(camera_pkg::MASTER_LINE_CYC - 1)) begin
				line_start = 1'b1;
				line_cnt_next = 10'h000;
			end
		end
		if (line_cnt_reg == 10'h3ff) begin
			line_cnt_next = line_cnt_reg;
		end
		words_left_next = words_left_reg;
		if (line_start) begin
			words_left_next = 10'(LINE_PIXELS);
		end else if (pop) begin
			words_left_next = words_left_reg - 10'h001;
		end
		case ({pin_reg[3], pin_reg[2]})
			2'b11: stage_next = camera_pkg::STAGES_96;
			2'b10: stage_next = camera_pkg::STAGES_64;
			2'b01: stage_next = WIDE_STAGE_SET ? camera_pkg::STAGES_32 : camera_pkg::STAGES_48;
			default: stage_next = WIDE_STAGE_SET ? camera_pkg::STAGES_16 : camera_pkg::STAGES_32;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			mode_reg <= camera_pkg::MODE_MASTER;
			sync_d_reg <= 1'b0;
			high_cnt_reg <= 4'h0;
			sync_armed_reg <= 1'b0;
			line_cnt_reg <= 10'h000;
			words_left_reg <= 10'h000;
			framing_reg <= 1'b0;
			stage_reg <= camera_pkg::STAGES_96;
		end else if (ce_i) begin
			mode_reg <= mode_next;
			sync_d_reg <= sync_d_next;
			high_cnt_reg <= high_cnt_next;
			sync_armed_reg <= sync_armed_next;
			line_cnt_reg <= line_cnt_next;
			words_left_reg <= words_left_next;
			framing_reg <= framing_next;
			stage_reg <= stage_next;
		end
	end

	// ------------------------------------------------------------
	// Gain and offset stores
	// ------------------------------------------------------------
	logic [9:0] gain_reg [4], gain_next [4];
	logic [9:0] offs_reg [4], offs_next [4];
	logic [9:0] nv_gain_reg [4], nv_gain_next [4];
	logic [9:0] nv_offs_reg [4], nv_offs_next [4];
	logic wr_en;
	logic [1:0] widx;
	assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
	assign widx = paddr_i[3:2];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gain_next[i] = gain_reg[i];
			offs_next[i] = offs_reg[i];
			nv_gain_next[i] = nv_gain_reg[i];
			nv_offs_next[i] = nv_offs_reg[i];
			if (nv_erase_i) begin
				nv_gain_next[i] = camera_pkg::GAIN_TYP;
				nv_offs_next[i] = camera_pkg::OFFSET_TYP;
			end else if (wr_en && paddr_i == camera_pkg::OFS_CTRL
					&& pwdata_i[camera_pkg::CTRL_NV_WRITE_BIT]) begin
				nv_gain_next[i] = gain_reg[i];
				nv_offs_next[i] = offs_reg[i];
			end
		end
		if (wr_en && paddr_i[7:4] == camera_pkg::OFS_GAIN_BASE[7:4] && paddr_i[1:0] == 2'h0) begin
			gain_next[widx] = pwdata_i[9:0];
		end
		if (wr_en && paddr_i[7:4] == camera_pkg::OFS_OFFSET_BASE[7:4] && paddr_i[1:0] == 2'h0) begin
			offs_next[widx] = pwdata_i[9:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 4; i++) begin
				gain_reg[i] <= nv_gain_reg[i];
				offs_reg[i] <= nv_offs_reg[i];
			end
		end else if (ce_i) begin
			gain_reg <= gain_next;
			offs_reg <= offs_next;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (ce_i) begin
			nv_gain_reg <= nv_gain_next;
			nv_offs_reg <= nv_offs_next;
		end
	end

	// ------------------------------------------------------------
	// Pixel correction and two-entry buffer
	// ------------------------------------------------------------
	camera_pkg::pixel_t corr;
	camera_pkg::pixel_t buf_reg [2], buf_next [2];
	logic [1:0] cnt_reg, cnt_next;
	logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic push;
	logic [10:0] lane_sum [4];
	logic [31:0] in_word, out_word;

	assign in_word = sensor_data_i;
	always_comb begin
		out_word = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			lane_sum[i] = 11'((18'(in_word[8*i +: 8]) * 18'(gain_reg[i])) >> camera_pkg::GAIN_SHIFT)
				+ 11'(offs_reg[i]);
			out_word[8*i +: 8] = (lane_sum[i] > 11'h0ff) ? 8'hff : lane_sum[i][7:0];
		end
		corr = out_word;
	end

	assign push = sensor_valid_i && sensor_ready_o;

	always_comb begin
		buf_next = buf_reg;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		cnt_next = cnt_reg;
		if (push) begin
			buf_next[wr_ptr_reg] = corr;
			wr_ptr_next = !wr_ptr_reg;
		end
		if (pop) begin
			rd_ptr_next = !rd_ptr_reg;
		end
		cnt_next = cnt_reg + 2'(push) - 2'(pop);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
			sensor_ready_o <= 1'b0;
		end else if (ce_i) begin
			buf_reg <= buf_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg <= cnt_next;
			sensor_ready_o <= (cnt_next < 2'h2) && !(cnt_next == 2'h1 && sensor_ready_o && push);
		end
	end

	// ------------------------------------------------------------
	// Video output
	// ------------------------------------------------------------
	logic pclk_next;
	logic [3:0] pdiv_reg, pdiv_next;
	logic line_valid_next;
	camera_pkg::pixel_t video_next;

	always_comb begin
		pdiv_next = pdiv_reg + 4'h1;
		pclk_next = pixel_clk_o;
		if (pdiv_reg >= 4'(camera_pkg::PIX_HALF_CYC - 1)) begin
			pdiv_next = 4'h0;
			pclk_next = !pixel_clk_o;
		end
		// New word only as the pixel clock falls, so it is stable at the next rise
		pop = pixel_clk_o && pclk_next == 1'b0 && words_left_reg != 10'h000
			&& cnt_reg != 2'h0 && rx_ready_i;
		line_valid_next = line_valid_o;
		video_next = video_o;
		if (pixel_clk_o && !pclk_next) begin
			line_valid_next = pop;
			video_next = pop ? buf_reg[rd_ptr_reg] : '0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			pdiv_reg <= 4'h0;
			pixel_clk_o <= 1'b0;
			line_valid_o <= 1'b0;
			video_o <= '0;
			stage_count_o <= camera_pkg::STAGES_96;
			framing_o <= 1'b0;
			slave_mode_o <= 1'b0;
		end else if (ce_i) begin
			pdiv_reg <= pdiv_next;
			pixel_clk_o <= pclk_next;
			line_valid_o <= line_valid_next;
			video_o <= video_next;
			stage_count_o <= stage_reg;
			framing_o <= framing_next;
			slave_mode_o <= (mode_next == camera_pkg::MODE_SLAVE);
		end
	end

	// ------------------------------------------------------------
	// APB read path
	// ------------------------------------------------------------
	logic [31:0] rd_next;
	logic err_next;

	always_comb begin
		rd_next = 32'h0000_0000;
		err_next = 1'b0;
		if (paddr_i[1:0] != 2'h0) begin
			err_next = 1'b1;
		end else if (paddr_i == camera_pkg::OFS_CTRL) begin
			rd_next = 32'h0000_0000;
		end else if (paddr_i == camera_pkg::OFS_STATUS) begin
			rd_next[camera_pkg::STATUS_SLAVE_BIT] = (mode_reg == camera_pkg::MODE_SLAVE);
			rd_next[camera_pkg::STATUS_FRAMING_BIT] = framing_reg;
			rd_next[camera_pkg::STATUS_STAGE_POS +: 7] = stage_reg;
		end else if (paddr_i[7:4] == camera_pkg::OFS_GAIN_BASE[7:4]) begin
			rd_next[9:0] = gain_reg[widx];
		end else if (paddr_i[7:4] == camera_pkg::OFS_OFFSET_BASE[7:4]) begin
			rd_next[9:0] = offs_reg[widx];
		end else if (paddr_i[7:4] == camera_pkg::OFS_NV_GAIN_BASE[7:4]) begin
			rd_next[9:0] = nv_gain_reg[widx];
		end else if (paddr_i[7:4] == camera_pkg::OFS_NV_OFFSET_BASE[7:4]) begin
			rd_next[9:0] = nv_offs_reg[widx];
		end else begin
			err_next = 1'b1;
		end
		if (pwrite_i && (paddr_i == camera_pkg::OFS_STATUS
				|| paddr_i[7:4] == camera_pkg::OFS_NV_GAIN_BASE[7:4]
				|| paddr_i[7:4] == camera_pkg::OFS_NV_OFFSET_BASE[7:4])) begin
			err_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && err_next;
			prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd_next : 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

/* hw/camera_pkg.sv */
`default_nettype none
package camera_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int PIXEL_CLK_HZ = 25_000_000;
	localparam int MASTER_LINE_HZ = 23191;
	localparam int FRAMING_LINE_HZ = 23190;
	localparam int SYNC_MIN_HIGH_NS = 100;
	localparam int PIX_HALF_RAW = CLK_HZ / (2 * PIXEL_CLK_HZ);
	localparam int PIX_HALF_CYC = (PIX_HALF_RAW < 1) ? 1 : PIX_HALF_RAW;
	localparam int MASTER_LINE_CYC = CLK_HZ / MASTER_LINE_HZ;
	localparam int FRAMING_LINE_CYC = CLK_HZ / FRAMING_LINE_HZ;
	localparam int SYNC_MIN_CYC = (SYNC_MIN_HIGH_NS * (CLK_HZ / 1000) + 999_999) / 1_000_000;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_GAIN_BASE = 8'h10;
	localparam logic [7:0] OFS_OFFSET_BASE = 8'h20;
	localparam logic [7:0] OFS_NV_GAIN_BASE = 8'h30;
	localparam logic [7:0] OFS_NV_OFFSET_BASE = 8'h40;
	localparam int CTRL_NV_WRITE_BIT = 0;
	localparam int STATUS_SLAVE_BIT = 0;
	localparam int STATUS_FRAMING_BIT = 1;
	localparam int STATUS_STAGE_POS = 8;

	// ------------------------------------------------------------
	// Typical values, stage counts and gain scale
	// ------------------------------------------------------------
	localparam logic [9:0] GAIN_TYP = 10'h190;
	localparam logic [9:0] OFFSET_TYP = 10'h040;
	localparam logic [6:0] STAGES_96 = 7'h60;
	localparam logic [6:0] STAGES_64 = 7'h40;
	localparam logic [6:0] STAGES_48 = 7'h30;
	localparam logic [6:0] STAGES_32 = 7'h20;
	localparam logic [6:0] STAGES_16 = 7'h10;
	localparam int GAIN_SHIFT = 8;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] video_lane_4;
		logic [7:0] video_lane_3;
		logic [7:0] video_lane_2;
		logic [7:0] video_lane_1;
	} pixel_t;

	typedef enum logic {
		MODE_MASTER = 1'b0,
		MODE_SLAVE = 1'b1
	} mode_t;

endpackage
`default_nettype wire

/* dv/tdi_line_camera_control_video_props.sv */
`default_nettype none
module tdi_line_camera_control_video_props #(
	parameter bit WIDE_STAGE_SET = 1'b0
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Pins and video
	input wire logic stage_count_sel_lo_i,
	input wire logic stage_count_sel_hi_i,
	input wire camera_pkg::pixel_t video_o,
	input wire logic pixel_clk_o,
	input wire logic line_valid_o,
	input wire logic [6:0] stage_count_o,
	input wire logic framing_o,
	input wire logic slave_mode_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	sequence setup_s;
		psel_i && !penable_i;
	endsequence
	sequence ro_write_s;
		setup_s ##0 (pwrite_i && paddr_i == 8'h30);
	endsequence
	apb_answer_a: assert property (setup_s |=> pready_o ##1 !pready_o)
		else $error("pready not one cycle after setup");
	ro_refuse_a: assert property (ro_write_s |=> pslverr_o)
		else $error("write to saved store not refused");
	blank_video_a: assert property (!line_valid_o |-> video_o == '0)
		else $error("lanes not zero outside line");
	lane_launch_a: assert property ($rose(line_valid_o) |-> $fell(pixel_clk_o))
		else $error("line valid rose off pixel clock fall");
	pclk_toggle_a: assert property (pixel_clk_o |=> !pixel_clk_o)
		else $error("pixel clock stuck high");
	stage_low_a: assert property ((!stage_count_sel_hi_i && !stage_count_sel_lo_i)[*8]
		|-> stage_count_o == (WIDE_STAGE_SET ? camera_pkg::STAGES_16 : camera_pkg::STAGES_32))
		else $error("select 00 gives wrong stage count");
	stage_high_a: assert property ((stage_count_sel_hi_i && stage_count_sel_lo_i)[*8]
		|-> stage_count_o == camera_pkg::STAGES_96)
		else $error("select 11 gives wrong stage count");
	slave_hold_a: assert property (slave_mode_o |=> slave_mode_o)
		else $error("slave mode left");
	framing_master_a: assert property (framing_o |-> !slave_mode_o)
		else $error("framing while slave");
endmodule
`default_nettype wire

/* dv/frame_grabber_model.sv */
`default_nettype none
module frame_grabber_model (
	// Clock
	input wire logic clk_sys_i,
	// Bench control
	input wire logic stall_i,
	input wire logic trig_i,
	input wire logic frame_req_i,
	// Camera side
	input wire logic pixel_clk_i,
	input wire logic line_valid_i,
	input wire camera_pkg::pixel_t video_i,
	output logic rx_ready_o,
	output logic line_sync_o,
	output logic framing_sel_n_o,
	output logic illum_o,
	output int words_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk_q = 1'b0;
	logic trig_q = 1'b0;
	int cnt = 0;
	int words_q = 0;
	logic sync_q = 1'b0;
	camera_pkg::pixel_t last_word;
	assign rx_ready_o = !stall_i;
	assign framing_sel_n_o = !frame_req_i;
	assign illum_o = frame_req_i;
	assign line_sync_o = sync_q;
	assign words_o = words_q;
	always @(posedge clk_sys_i) begin
		pclk_q <= pixel_clk_i;
		trig_q <= trig_i;
		if (pixel_clk_i && !pclk_q && line_valid_i) begin
			words_q <= words_q + 1;
			last_word <= video_i;
		end
		if (trig_i && !trig_q)
			cnt <= 4;
		else if (cnt != 0)
			cnt <= cnt - 1;
		sync_q <= (cnt != 0);
	end
endmodule
`default_nettype wire

/* dv/tdi_line_camera_control_video_tb.sv */
`default_nettype none
module tdi_line_camera_control_video_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic nv_erase_i = 1'b1;
	logic stage_count_sel_lo_i = 1'b1;
	logic stage_count_sel_hi_i = 1'b1;
	logic sensor_valid_i = 1'b1;
	camera_pkg::pixel_t sensor_data_i = 32'h40302010;
	logic stall = 1'b1;
	logic trig = 1'b0;
	logic frame_req = 1'b0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, sensor_ready_o, pixel_clk_o, line_valid_o;
	logic framing_o, slave_mode_o, rx_ready_i, line_sync_in_i, framing_sel_n_i;
	camera_pkg::pixel_t video_o;
	logic [6:0] stage_count_o;
	logic [6:0] stage_tab [4] = '{7'h20, 7'h30, 7'h40, 7'h60};
	logic [31:0] rd;
	logic err;
	int words, w, n;
	int fails = 0;
	int samples_checked = 0;
	always #25 clk_sys_i = !clk_sys_i;
	tdi_line_camera_control_video #(.LINE_PIXELS(4), .WIDE_STAGE_SET(1'b0))
		tdi_line_camera_control_video_i (.clk_sys_i, .resetn_i, .ce_i(1'b1), .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.nv_erase_i, .line_sync_in_i, .framing_sel_n_i, .stage_count_sel_lo_i,
		.stage_count_sel_hi_i, .sensor_valid_i, .sensor_data_i, .sensor_ready_o, .video_o,
		.pixel_clk_o, .line_valid_o, .rx_ready_i, .stage_count_o, .framing_o, .slave_mode_o);
	frame_grabber_model frame_grabber_model_i (.clk_sys_i, .stall_i(stall), .trig_i(trig),
		.frame_req_i(frame_req), .pixel_clk_i(pixel_clk_o), .line_valid_i(line_valid_o),
		.video_i(video_o), .rx_ready_o(rx_ready_i), .line_sync_o(line_sync_in_i),
		.framing_sel_n_o(framing_sel_n_i), .illum_o(), .words_o(words));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1 && k < 50) begin
			@(posedge clk_sys_i);
			k++;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (k == 50)
			fails++;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("read data", rd, e);
		chk("read error", {31'h0, err}, 32'h0);
	endtask
	task automatic power_cycle;
		resetn_i <= 1'b0;
		repeat (16) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
	endtask
	task automatic print_verdict;
		$display("checked %0d failed %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#1_000_000;
		fails++;
		print_verdict;
	end
	initial begin
		@(posedge clk_sys_i);
		nv_erase_i <= 1'b0;
		repeat (15) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		chk("stages", stage_count_o, camera_pkg::STAGES_96);
		rchk(8'h10, 32'h190);
		rchk(8'h2c, 32'h40);
		apb(1'b1, 8'h14, 32'h3ff);
		rchk(8'h14, 32'h3ff);
		rchk(8'h34, 32'h190);
		apb(1'b1, 8'h00, 32'h1);
		rchk(8'h34, 32'h3ff);
		apb(1'b1, 8'h30, 32'h5);
		chk("ro error", {31'h0, err}, 32'h1);
		rchk(8'h30, 32'h190);
		apb(1'b0, 8'h08, 32'h0);
		chk("map error", {31'h0, err}, 32'h1);
		apb(1'b1, 8'h14, 32'h55);
		power_cycle;
		rchk(8'h14, 32'h3ff);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			{stage_count_sel_hi_i, stage_count_sel_lo_i} <= i[1:0];
			repeat (10) @(posedge clk_sys_i);
			chk("stages", stage_count_o, stage_tab[i]);
		end
		frame_req <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		chk("framing", framing_o, 1'b1);
		$display("test pins done");
		repeat (1000) @(posedge clk_sys_i);
		chk("full buffer", sensor_ready_o, 1'b0);
		chk("stalled words", words, 0);
		stall <= 1'b0;
		repeat (2000) @(posedge clk_sys_i);
		chk("master lines", words >= 4 && words <= 12, 1'b1);
		chk("lane data", frame_grabber_model_i.last_word, 32'ha48bbf59);
		$display("test video done");
		trig <= 1'b1;
		n = 0;
		while (slave_mode_o !== 1'b1 && n < 100) begin
			@(posedge clk_sys_i);
			n++;
		end
		trig <= 1'b0;
		chk("slave", slave_mode_o, 1'b1);
		chk("framing", framing_o, 1'b0);
		repeat (200) @(posedge clk_sys_i);
		w = words;
		repeat (2000) @(posedge clk_sys_i);
		chk("no free lines", words, w);
		trig <= 1'b1;
		repeat (200) @(posedge clk_sys_i);
		trig <= 1'b0;
		chk("sync line", words, w + 4);
		power_cycle;
		@(posedge clk_sys_i);
		chk("master again", slave_mode_o, 1'b0);
		$display("test slave done");
		print_verdict;
	end
endmodule
bind tdi_line_camera_control_video tdi_line_camera_control_video_props #(
	.WIDE_STAGE_SET(WIDE_STAGE_SET)) props_i (.clk_sys_i, .resetn_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pready_o, .pslverr_o, .stage_count_sel_lo_i, .stage_count_sel_hi_i,
	.video_o, .pixel_clk_o, .line_valid_o, .stage_count_o, .framing_o, .slave_mode_o);
`default_nettype wire
